// ### src/clock_select_pkg.sv
// constants for the oscillator, pll and clock select block
// assumes a single 10 MHz system clock and a 2-bit register index bus
package clock_select_pkg;

    // register indices on the plain register port
    localparam logic [1:0] OSC_CTRL_ADDR     = 2'h0;
    localparam logic [1:0] CLOCK_DIVISOR_ADDR = 2'h1;
    localparam logic [1:0] PLL_FEEDBACK_ADDR = 2'h2;
    localparam logic [1:0] FRC_TUNE_ADDR     = 2'h3;

    // field positions
    localparam int CUR_SRC_LSB  = 12;
    localparam int NEW_SRC_LSB  = 8;
    localparam int SW_REQ_BIT   = 0;
    localparam int FRC_POST_LSB = 8;
    localparam int PLL_POST_LSB = 6;
    localparam int PLL_PRE_LSB  = 0;

    // reset values
    localparam logic [2:0] FRC_POST_RST = 3'h0;
    localparam logic [1:0] PLL_POST_RST = 2'h1;
    localparam logic [4:0] PLL_PRE_RST  = 5'h00;
    localparam logic [8:0] PLL_FBD_RST  = 9'h030;
    localparam logic [5:0] FRC_TUNE_RST = 6'h00;

    // source codes
    localparam logic [2:0] SRC_FRC       = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL   = 3'h1;
    localparam logic [2:0] SRC_PRI       = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL   = 3'h3;
    localparam logic [2:0] SRC_SEC       = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC_SOURCE      = 3'h5;
    localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_FRC_DIVN  = 3'h7;

    // primary oscillator modes
    localparam logic [1:0] PRI_EXT_CLOCK = 2'h0;
    localparam logic [1:0] PRI_CRYSTAL   = 2'h1;
    localparam logic [1:0] PRI_HIGH_SPEED = 2'h2;

    // pll postscale codes
    localparam logic [1:0] POST_DIV2 = 2'h0;
    localparam logic [1:0] POST_DIV4 = 2'h1;
    localparam logic [1:0] POST_DIV8 = 2'h3;

    // fixed divisors and counts
    localparam logic [8:0]  DIV16_VALUE   = 9'h010;
    localparam logic [2:0]  SWITCH_EDGES  = 3'h4;
    localparam logic [15:0] ACC_LIMIT     = 16'h8000;

    typedef enum logic [1:0] {SW_IDLE, SW_WAIT} switch_phase_t;

endpackage

// ### src/clock_select.sv
// oscillator source selection, fast rc postscaler, pll model and fcy divider
// assumes oscillator inputs are asynchronous and slower than half of clk;
// clock outputs are one-cycle enable ticks on clk, not real clocks
`timescale 1ns/1ns
`default_nettype none

module clock_select (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [2:0]  initial_source_cfg,
    input  wire logic [1:0]  primary_mode_cfg,
    input  wire logic        fast_rc_osc,
    input  wire logic        osc_in_pin,
    input  wire logic        secondary_osc,
    input  wire logic        low_power_rc_osc,
    input  wire logic [1:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [15:0] rdata,
    output logic             fosc_tick,
    output logic             instr_clock_tick,
    output logic             peripheral_clock_tick,
    output logic             low_power_rc_ref_tick,
    output logic      [2:0]  current_source_code,
    output logic      [1:0]  primary_mode,
    output logic             crystal_drive_en,
    output logic             high_gain_en,
    output logic      [5:0]  fast_rc_trim
);
    import clock_select_pkg::*;

    typedef struct packed {
        logic [3:0]    sync1;
        logic [3:0]    sync2;
        logic [3:0]    sync3;
        logic          cfg_done;
        logic [2:0]    cur_src;
        logic [2:0]    new_src;
        logic [1:0]    prim_mode;
        logic          sw_req;
        switch_phase_t sw_phase;
        logic [2:0]    sw_cnt;
        logic [2:0]    frc_post;
        logic [1:0]    pll_post;
        logic [4:0]    pll_pre;
        logic [8:0]    pll_fbd;
        logic [5:0]    frc_trim;
        logic [7:0]    frc_cnt;
        logic [5:0]    pre_cnt;
        logic [15:0]   acc;
        logic          fosc;
        logic          fcy_tog;
        logic          fcy;
        logic          low_power_rc_source;
        logic          xtal_en;
        logic          gain_en;
        logic [15:0]   rdata;
    } state_t;

    ////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // raw edge of the oscillator that underlies a source code
    function automatic logic base_edge(input logic [2:0] src, input logic [3:0] e);
        unique case (src)
            SRC_PRI, SRC_PRI_PLL: base_edge = e[1];
            SRC_SEC:              base_edge = e[2];
            SRC_LOW_POWER_RC_SOURCE:             base_edge = e[3];
            default:              base_edge = e[0];
        endcase
    endfunction

    function automatic logic is_pll(input logic [2:0] src);
        is_pll = (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
    endfunction

    function automatic logic [8:0] frc_divisor(input logic [2:0] sel);
        frc_divisor = (sel == 3'h7) ? 9'h100 : (9'h001 << sel);
    endfunction

    function automatic logic [3:0] post_divisor(input logic [1:0] sel);
        unique case (sel)
            POST_DIV2: post_divisor = 4'h2;
            POST_DIV8: post_divisor = 4'h8;
            default:   post_divisor = 4'h4;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_meta_q;
    logic rst_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    state_t      q;
    state_t      d;
    logic [3:0]  edge_s;
    logic [8:0]  frc_div;
    logic        frc_tick;
    logic        pll_in;
    logic        pre_tick;
    logic [15:0] n2;
    logic [15:0] m_fac;
    logic        drain;

    assign edge_s = q.sync2 & ~q.sync3;
    assign frc_div = (q.cur_src == SRC_FRC_DIV16) ? DIV16_VALUE : frc_divisor(q.frc_post);
    assign frc_tick = edge_s[0] && ({1'b0, q.frc_cnt} == frc_div - 9'h001);
    assign pll_in = (q.cur_src == SRC_FRC_PLL) ? edge_s[0] : edge_s[1];
    // six-bit count so the largest prescale of 33 does not wrap
    assign pre_tick = pll_in && (q.pre_cnt == {1'b0, q.pll_pre} + 6'h01);
    assign n2 = {12'h000, post_divisor(q.pll_post)};
    assign m_fac = {7'h00, q.pll_fbd} + 16'h0002;
    assign drain = is_pll(q.cur_src) && (q.acc >= n2);

    always_comb begin
        d = q;
        if (ce) begin
            d.sync1 = {low_power_rc_osc, secondary_osc, osc_in_pin, fast_rc_osc};
            d.sync2 = q.sync1;
            d.sync3 = q.sync2;
            d.rdata = 16'h0000;
            d.fosc  = 1'b0;
            d.fcy   = 1'b0;
            d.low_power_rc_source  = edge_s[3];
            if (!q.cfg_done) begin
                // nonvolatile fields land once, after reset release
                d.cfg_done  = 1'b1;
                d.cur_src   = initial_source_cfg;
                d.new_src   = initial_source_cfg;
                d.prim_mode = primary_mode_cfg;
                d.xtal_en   = (primary_mode_cfg == PRI_CRYSTAL)
                              || (primary_mode_cfg == PRI_HIGH_SPEED);
                d.gain_en   = (primary_mode_cfg == PRI_HIGH_SPEED);
            end else begin
                // fast rc postscaler and divide-by-16 share one counter
                if (edge_s[0]) begin
                    d.frc_cnt = frc_tick ? 8'h00 : q.frc_cnt + 8'h01;
                end
                // pll: prescale, multiply by m, drain one tick per n2 credits
                if (pll_in) begin
                    d.pre_cnt = pre_tick ? 6'h00 : q.pre_cnt + 6'h01;
                end
                d.acc = q.acc;
                if (pre_tick && is_pll(q.cur_src) && (q.acc < ACC_LIMIT)) begin
                    d.acc = d.acc + m_fac;
                end
                if (drain) begin
                    d.acc = d.acc - n2;
                end
                unique case (q.cur_src)
                    SRC_FRC_PLL, SRC_PRI_PLL:  d.fosc = drain;
                    SRC_FRC_DIV16, SRC_FRC_DIVN: d.fosc = frc_tick;
                    default:                   d.fosc = base_edge(q.cur_src, edge_s);
                endcase
                if (!is_pll(q.cur_src)) begin
                    d.acc     = 16'h0000;
                    d.pre_cnt = 6'h00;
                end
                // fcy and peripheral time base at half the oscillator rate
                if (q.fosc) begin
                    d.fcy_tog = ~q.fcy_tog;
                    d.fcy     = q.fcy_tog;
                end
                // switch completes after a few edges of the new source
                if (q.sw_phase == SW_WAIT && base_edge(q.new_src, edge_s)) begin
                    if (q.sw_cnt == SWITCH_EDGES - 3'h1) begin
                        d.cur_src  = q.new_src;
                        d.sw_req   = 1'b0;
                        d.sw_phase = SW_IDLE;
                        d.frc_cnt  = 8'h00;
                        d.acc      = 16'h0000;
                    end else begin
                        d.sw_cnt = q.sw_cnt + 3'h1;
                    end
                end
            end
            // register writes; a new request wins over a completing one
            if (wr_stb) begin
                unique case (addr)
                    OSC_CTRL_ADDR: begin
                        d.new_src = wdata[NEW_SRC_LSB +: 3];
                        if (wdata[SW_REQ_BIT]) begin
                            d.sw_req   = 1'b1;
                            d.sw_phase = SW_WAIT;
                            d.sw_cnt   = 3'h0;
                        end
                    end
                    CLOCK_DIVISOR_ADDR: begin
                        d.frc_post = wdata[FRC_POST_LSB +: 3];
                        d.pll_post = wdata[PLL_POST_LSB +: 2];
                        d.pll_pre  = wdata[PLL_PRE_LSB +: 5];
                    end
                    PLL_FEEDBACK_ADDR: d.pll_fbd = wdata[8:0];
                    FRC_TUNE_ADDR:     d.frc_trim = wdata[5:0];
                endcase
            end
            if (rd_stb) begin
                unique case (addr)
                    OSC_CTRL_ADDR: begin
                        d.rdata[CUR_SRC_LSB +: 3] = q.cur_src;
                        d.rdata[NEW_SRC_LSB +: 3] = q.new_src;
                        d.rdata[SW_REQ_BIT]       = q.sw_req;
                    end
                    CLOCK_DIVISOR_ADDR: begin
                        d.rdata[FRC_POST_LSB +: 3] = q.frc_post;
                        d.rdata[PLL_POST_LSB +: 2] = q.pll_post;
                        d.rdata[PLL_PRE_LSB +: 5]  = q.pll_pre;
                    end
                    PLL_FEEDBACK_ADDR: d.rdata[8:0] = q.pll_fbd;
                    FRC_TUNE_ADDR:     d.rdata[5:0] = q.frc_trim;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            q          <= '0;
            q.cur_src  <= SRC_FRC;
            q.sw_phase <= SW_IDLE;
            q.frc_post <= FRC_POST_RST;
            q.pll_post <= PLL_POST_RST;
            q.pll_pre  <= PLL_PRE_RST;
            q.pll_fbd  <= PLL_FBD_RST;
            q.frc_trim <= FRC_TUNE_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from state flops

    assign rdata                 = q.rdata;
    assign fosc_tick             = q.fosc;
    assign instr_clock_tick      = q.fcy;
    assign peripheral_clock_tick = q.fcy;
    assign low_power_rc_ref_tick = q.low_power_rc_source;
    assign current_source_code   = q.cur_src;
    assign primary_mode          = q.prim_mode;
    assign crystal_drive_en      = q.xtal_en;
    assign high_gain_en          = q.gain_en;
    assign fast_rc_trim          = q.frc_trim;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_q);

    cfg_load_a: assert property ($rose(q.cfg_done) |-> q.cur_src == $past(initial_source_cfg))
        else $error("power-on source not taken from config");
    fcy_half_a: assert property (q.fcy && $past(ce) |-> $past(q.fosc) && !q.fcy_tog)
        else $error("instruction tick not on every second oscillator tick");
    pll_bypass_a: assert property (ce && q.cfg_done && q.sw_phase == SW_IDLE
            && (q.cur_src == SRC_SEC || q.cur_src == SRC_LOW_POWER_RC_SOURCE) |=> q.acc == 16'h0000)
        else $error("pll used by a bypass source");
    switch_done_a: assert property ($fell(q.sw_req) |-> q.cur_src == $past(q.new_src))
        else $error("switch cleared without changing source");
    low_power_rc_source_ref_a: assert property (ce |=> q.low_power_rc_source == $past(edge_s[3]))
        else $error("low-power reference tick lost");
    frc_post_a: assert property (ce && q.cfg_done && q.cur_src == SRC_FRC_DIVN
            && q.sw_phase == SW_IDLE |=> q.fosc == $past(frc_tick))
        else $error("postscaled tick does not follow counter");
    pll_drain_a: assert property (ce && drain && !pre_tick && q.sw_phase == SW_IDLE
            |=> q.acc == $past(q.acc) - $past(n2))
        else $error("pll credit not reduced by postscale");
    post_write_a: assert property (ce && wr_stb && addr == CLOCK_DIVISOR_ADDR
            |=> q.pll_post == $past(wdata[7:6]) && q.pll_pre == $past(wdata[4:0]))
        else $error("divisor write not stored");

endmodule

`default_nettype wire

// ### verification/osc_sources.sv
// far-side oscillator model: fast rc, primary pin, secondary and low-power rc
// assumes a 100 ns system clock; every half period here is several clk periods
`timescale 1ns/1ns
`default_nettype none

module osc_sources #(
    parameter int FRC_HALF  = 503,
    parameter int PRI_HALF  = 401,
    parameter int SEC_HALF  = 707,
    parameter int LOW_POWER_RC_SOURCE_HALF = 1003
) (
    output var logic fast_rc_osc,
    output var logic osc_in_pin,
    output var logic secondary_osc,
    output var logic low_power_rc_osc
);
    ////////////////////////////////////////////////////////////
    // odd half periods keep every edge except each 50th off the clk edges; the 50th edge and every 100th after it race the sync stage
    initial begin
        fast_rc_osc = 1'b0;
        osc_in_pin = 1'b0;
        secondary_osc = 1'b0;
        low_power_rc_osc = 1'b0;
    end
    always #(FRC_HALF) fast_rc_osc = ~fast_rc_osc;
    always #(PRI_HALF) osc_in_pin = ~osc_in_pin;
    always #(SEC_HALF) secondary_osc = ~secondary_osc;
    always #(LOW_POWER_RC_SOURCE_HALF) low_power_rc_osc = ~low_power_rc_osc;
endmodule

`default_nettype wire

// ### verification/tb_clock_select.sv
// testbench for clock_select: register tasks, source switches, tick rates
// assumes osc_sources drives the four oscillator inputs
`timescale 1ns/1ns
`default_nettype none

module tb_clock_select;
    import clock_select_pkg::*;

    localparam int W = 2000;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic [2:0]  init_cfg = 3'h7;
    logic [1:0]  mode_cfg = 2'h0;
    logic        frc_w, pri_w, sec_w, low_power_rc_source_w;
    logic [1:0]  addr = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [15:0] rdata, rd_v;
    logic        fosc_tick, fcy_tick, per_tick, lp_tick, xtal_en, gain_en;
    logic [2:0]  cur_src;
    logic [1:0]  pri_mode;
    logic [5:0]  trim;
    int          failures = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          nf, ni, np, nl, k;
    int          exp_rate [8] = '{200, 100, 250, 125, 142, 100, 12, 50};
    int          post_rate [4] = '{400, 200, 200, 100};

    osc_sources osc_sources_i (.fast_rc_osc(frc_w), .osc_in_pin(pri_w),
        .secondary_osc(sec_w), .low_power_rc_osc(low_power_rc_source_w));

    clock_select clock_select_i (.clk(clk), .rst_n(rst_n), .ce(ce),
        .initial_source_cfg(init_cfg), .primary_mode_cfg(mode_cfg), .fast_rc_osc(frc_w),
        .osc_in_pin(pri_w), .secondary_osc(sec_w), .low_power_rc_osc(low_power_rc_source_w),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .fosc_tick(fosc_tick), .instr_clock_tick(fcy_tick), .peripheral_clock_tick(per_tick),
        .low_power_rc_ref_tick(lp_tick), .current_source_code(cur_src),
        .primary_mode(pri_mode), .crystal_drive_en(xtal_en), .high_gain_en(gain_en),
        .fast_rc_trim(trim));

    ////////////////////////////////////////////////////////////
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // tick counts jitter with the sync stage, so a count near enough reads as exact
    function automatic logic [15:0] near(input int got, input int exp, input int tol);
        return (got >= exp - tol && got <= exp + tol) ? 16'(exp) : 16'(got);
    endfunction

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        rd_v = rdata;
    endtask

    task automatic do_reset(input logic [2:0] c, input logic [1:0] m);
        @(posedge clk);
        rst_n <= 1'b0;
        init_cfg <= c;
        mode_cfg <= m;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic switch_to(input logic [2:0] s);
        wr(OSC_CTRL_ADDR, {5'h00, s, 8'h01});
        k = 0;
        do begin
            rd(OSC_CTRL_ADDR);
            k++;
        end while (rd_v[SW_REQ_BIT] !== 1'b0 && k < 200);
        check("switch done", rd_v, {1'b0, s, 1'b0, s, 8'h00});
        check("current src", {13'h0, cur_src}, {13'h0, s});
    endtask

    task automatic measure();
        nf = 0;
        ni = 0;
        np = 0;
        nl = 0;
        repeat (W) begin
            @(posedge clk);
            #1;
            nf += fosc_tick;
            ni += fcy_tick;
            np += per_tick;
            nl += lp_tick;
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        for (int m = 0; m < 3; m++) begin
            do_reset(3'h7, m[1:0]);
            check("primary mode", {14'h0, pri_mode}, m[15:0]);
            check("drive en", {15'h0, xtal_en}, {15'h0, m != 0});
            check("gain en", {15'h0, gain_en}, {15'h0, m == 2});
            check("unprog src", {13'h0, cur_src}, 16'h0007);
        end
        rd(OSC_CTRL_ADDR);
        check("osc ctrl", rd_v, 16'h7700);
        @(posedge clk);
        #1;
        check("rdata idle", rdata, 16'h0000);
        rd(CLOCK_DIVISOR_ADDR);
        check("divisor", rd_v, {5'h00, FRC_POST_RST, PLL_POST_RST, 1'b0, PLL_PRE_RST});
        rd(PLL_FEEDBACK_ADDR);
        check("feedback", rd_v, {7'h00, PLL_FBD_RST});
        rd(FRC_TUNE_ADDR);
        check("trim rst", rd_v, {10'h000, FRC_TUNE_RST});
        do_reset(SRC_FRC, PRI_CRYSTAL);
        check("cfg src", {13'h0, cur_src}, 16'h0000);
        wr(CLOCK_DIVISOR_ADDR, 16'hffff);
        rd(CLOCK_DIVISOR_ADDR);
        check("divisor rw", rd_v, 16'h07df);
        wr(FRC_TUNE_ADDR, 16'hffff);
        rd(FRC_TUNE_ADDR);
        check("trim rw", rd_v, 16'h003f);
        check("trim port", {10'h000, trim}, 16'h003f);
        @(posedge clk);
        ce <= 1'b0;
        wr(FRC_TUNE_ADDR, 16'h0015);
        @(posedge clk);
        ce <= 1'b1;
        rd(FRC_TUNE_ADDR);
        check("trim frozen", rd_v, 16'h003f);
        // n1 2, n2 8, m 8, fast rc postscale /4
        wr(CLOCK_DIVISOR_ADDR, 16'h02c0);
        wr(PLL_FEEDBACK_ADDR, 16'h0006);
        // ascending order never jumps straight from one pll mode to the other
        for (int s = 0; s < 8; s++) begin
            switch_to(s[2:0]);
            measure();
            check("fosc rate", near(nf, exp_rate[s], exp_rate[s] / 16 + 3), 16'(exp_rate[s]));
            check("fcy rate", near(ni, nf / 2, 1), 16'(nf / 2));
            check("fp vs fcy", 16'(np), 16'(ni));
            check("low_power_rc_source ref", near(nl, 100, 3), 16'd100);
        end
        switch_to(SRC_FRC);
        switch_to(SRC_FRC_PLL);
        for (int p = 0; p < 4; p++) begin
            wr(CLOCK_DIVISOR_ADDR, {8'h02, p[1:0], 6'h00});
            measure();
            check("pll post", near(nf, post_rate[p], post_rate[p] / 16 + 3), 16'(post_rate[p]));
        end
        wrap_up();
    end
endmodule

`default_nettype wire
